// ---- include/plut_pkg.sv ----
// Package for the pixel luminance lookup block: register map, formats, widths.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package plut_pkg;

  localparam int unsigned PIX_W       = 12;
  localparam int unsigned OUT8_W      = 8;
  localparam int unsigned DROP_BITS   = 4;
  localparam int unsigned TBL_DEPTH   = 4096;
  localparam int unsigned IDX_W       = 12;
  localparam int unsigned STEP_SHIFT  = 3;
  localparam int unsigned ADDR_W      = 4;

  localparam logic [11:0] LAST_USED   = 12'h0FF8;
  localparam logic [2:0]  FRAC_ZERO   = 3'h0;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_SELECTOR = 4'h0;
  localparam logic [ADDR_W-1:0] REG_INDEX    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_VALUE    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_FMT_LSB = 4;
  localparam int unsigned CTRL_FMT_W   = 2;

  localparam logic [31:0] SELECTOR_LUMINANCE = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

  typedef enum logic [1:0] {
    FMT_MOSAIC_16  = 2'h0,
    FMT_MOSAIC_12P = 2'h1,
    FMT_MOSAIC_8   = 2'h2,
    FMT_LUMA_CHROMA = 2'h3
  } plut_format_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_DONE = 2'b11
  } plut_bus_state_type;

endpackage

// ---- rtl/plut_top.sv ----
// Pixel luminance lookup: 12-bit samples mapped through an interpolated table.
// Assumes pixel samples and bus synchronous to I_CLK; reset synchronous.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module plut_top
  import plut_pkg::*;
#(
  parameter int unsigned DEPTH = TBL_DEPTH
)(
  input  wire logic              I_CLK,
  input  wire logic              I_RST_B,
  input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  input  wire logic [3:0]        I_AVS_BYTEENABLE,
  output logic [31:0]            O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST,
  input  wire logic [PIX_W-1:0]  I_PIX_DATA,
  input  wire logic              I_PIX_VALID,
  output logic [PIX_W-1:0]       O_PIX_DATA,
  output logic                   O_PIX_VALID
);

  // Interpolation step
  function automatic logic [PIX_W-1:0] interp(input logic [PIX_W-1:0] lo,
                                              input logic [PIX_W-1:0] hi,
                                              input logic [2:0]       frac);
    logic signed [PIX_W+4:0] diff;
    logic signed [PIX_W+4:0] prod;
    logic signed [PIX_W+4:0] sum;
    diff = $signed({5'h0_0, hi}) - $signed({5'h0_0, lo});
    prod = diff * $signed({14'h0000, frac});
    sum  = $signed({5'h0_0, lo}) + (prod >>> STEP_SHIFT);
    return sum[PIX_W-1:0];
  endfunction

  // Samples at or above the last used entry take no interpolation
  function automatic logic is_top(input logic [PIX_W-1:0] s);
    return (s >= LAST_USED);
  endfunction

  logic [PIX_W-1:0] table_mem [DEPTH];

  logic [IDX_W-1:0] table_entry_index_ff;
  logic [CTRL_FMT_W-1:0] fmt_ff;
  logic             table_enable_ff;
  logic [31:0]      rdata_ff;
  logic [PIX_W-1:0] rd_entry_ff;
  plut_bus_state_type st_ff;

  logic [PIX_W-1:0] s1_sample_ff;
  logic [PIX_W-1:0] s1_lo_ff;
  logic [PIX_W-1:0] s1_hi_ff;
  logic             s1_valid_ff;
  logic             s1_en_ff;
  logic [CTRL_FMT_W-1:0] s1_fmt_ff;
  logic [PIX_W-1:0] pix_out_ff;
  logic             pix_valid_ff;

  // Bus decode
  wire logic acc         = I_AVS_READ | I_AVS_WRITE;
  wire logic hit_sel     = (I_AVS_ADDRESS == REG_SELECTOR);
  wire logic hit_idx     = (I_AVS_ADDRESS == REG_INDEX);
  wire logic hit_val     = (I_AVS_ADDRESS == REG_VALUE);
  wire logic hit_ctrl    = (I_AVS_ADDRESS == REG_CTRL);
  wire logic wr_go       = I_AVS_WRITE & (st_ff == ST_IDLE);
  wire logic be_lo       = I_AVS_BYTEENABLE[0];
  wire logic be_hi       = I_AVS_BYTEENABLE[1];
  wire logic wr_idx      = wr_go & hit_idx;
  wire logic wr_val      = wr_go & hit_val & be_lo & be_hi;
  wire logic wr_ctrl     = wr_go & hit_ctrl & be_lo;
  wire logic [PIX_W-1:0] wdata12 = I_AVS_WRITEDATA[PIX_W-1:0];
  wire logic hit_none    = ~(hit_sel | hit_idx | hit_val | hit_ctrl);

  // Reads take two cycles to fetch the table word; writes complete at once
  assign O_AVS_WAITREQUEST = acc & ~(I_AVS_WRITE & (st_ff == ST_IDLE))
                             & ~(st_ff == ST_DONE);
  assign O_AVS_READDATA    = rdata_ff;

  plut_bus_state_type nxt_st;
  always_comb
  begin
    case (st_ff)
      ST_IDLE: nxt_st = I_AVS_READ ? ST_READ : ST_IDLE;
      ST_READ: nxt_st = ST_DONE;
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  wire logic [31:0] nxt_rdata =
      hit_sel  ? SELECTOR_LUMINANCE :
      hit_idx  ? {{(32-IDX_W){1'b0}}, table_entry_index_ff} :
      hit_val  ? {{(32-PIX_W){1'b0}}, rd_entry_ff} :
      hit_ctrl ? {{(32-CTRL_FMT_LSB-CTRL_FMT_W){1'b0}}, fmt_ff,
                  {(CTRL_FMT_LSB-1){1'b0}}, table_enable_ff} :
                 UNMAPPED_READ;

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      st_ff                <= ST_IDLE;
      table_entry_index_ff <= '0;
      table_enable_ff      <= 1'b0;
      fmt_ff               <= FMT_MOSAIC_16;
      rdata_ff             <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      if (wr_idx)
        table_entry_index_ff <= I_AVS_WRITEDATA[IDX_W-1:0];
      if (wr_ctrl)
      begin
        table_enable_ff <= I_AVS_WRITEDATA[CTRL_EN_BIT];
        fmt_ff <= I_AVS_WRITEDATA[CTRL_FMT_LSB +: CTRL_FMT_W];
      end
      if (st_ff == ST_READ)
        rdata_ff <= nxt_rdata;
    end
  end

  // Table port: write from bus, read-back of indexed entry
  always_ff @(posedge I_CLK)
  begin
    if (wr_val)
      table_mem[table_entry_index_ff] <= wdata12;
    rd_entry_ff <= table_mem[table_entry_index_ff];
  end

  // Pixel lookup addresses
  wire logic [PIX_W-1:0] base_idx = {I_PIX_DATA[PIX_W-1:STEP_SHIFT], FRAC_ZERO};
  wire logic             above    = is_top(I_PIX_DATA);
  wire logic [PIX_W-1:0] lo_idx   = above ? LAST_USED : base_idx;
  wire logic [PIX_W-1:0] hi_idx   = above ? LAST_USED
                                          : base_idx + (PIX_W'(1) << STEP_SHIFT);

  always_ff @(posedge I_CLK)
  begin
    s1_lo_ff     <= table_mem[lo_idx];
    s1_hi_ff     <= table_mem[hi_idx];
    s1_sample_ff <= I_PIX_DATA;
  end

  wire logic [2:0] s1_frac = is_top(s1_sample_ff) ? FRAC_ZERO
                                                  : s1_sample_ff[STEP_SHIFT-1:0];
  wire logic [PIX_W-1:0] mapped  = interp(s1_lo_ff, s1_hi_ff, s1_frac);
  wire logic [PIX_W-1:0] sel12   = s1_en_ff ? mapped : s1_sample_ff;
  wire logic             narrow  = (s1_fmt_ff == FMT_MOSAIC_8) || (s1_fmt_ff == FMT_LUMA_CHROMA);
  wire logic [PIX_W-1:0] shaped  = narrow ? {{DROP_BITS{1'b0}}, sel12[PIX_W-1:DROP_BITS]}
                                          : sel12;

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_B)
    begin
      s1_valid_ff  <= 1'b0;
      s1_en_ff     <= 1'b0;
      s1_fmt_ff    <= FMT_MOSAIC_16;
      pix_valid_ff <= 1'b0;
      pix_out_ff   <= '0;
    end
    else
    begin
      s1_valid_ff  <= I_PIX_VALID;
      s1_en_ff     <= table_enable_ff;
      s1_fmt_ff    <= fmt_ff;
      pix_valid_ff <= s1_valid_ff;
      if (s1_valid_ff)
        pix_out_ff <= shaped;
    end
  end

  assign O_PIX_DATA  = pix_out_ff;
  assign O_PIX_VALID = pix_valid_ff;

  // Checks
  sequence s_pix_in;
    I_PIX_VALID ##1 I_RST_B;
  endsequence

  sequence s_pix_none;
    !I_PIX_VALID ##1 I_RST_B;
  endsequence

  sequence s_bypass_in;
    (I_PIX_VALID && !table_enable_ff && fmt_ff == FMT_MOSAIC_16)
      ##1 (!s1_en_ff && s1_fmt_ff == FMT_MOSAIC_16);
  endsequence

  sequence s_read_fetch;
    O_AVS_WAITREQUEST [*2] ##1 !O_AVS_WAITREQUEST;
  endsequence

  // Pixel path checks, then index, enable and selector register checks
  property p_bypass;
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_bypass_in |=> (O_PIX_DATA == $past(I_PIX_DATA, 2));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass pixel changed");

  property p_latency;
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_pix_in |=> O_PIX_VALID;
  endproperty
  a_latency: assert property (p_latency) else $error("pixel valid lost");

  property p_no_extra;
    @(posedge I_CLK) disable iff (!I_RST_B)
    s_pix_none |=> !O_PIX_VALID;
  endproperty
  a_no_extra: assert property (p_no_extra) else $error("pixel valid without sample");

  property p_hold;
    @(posedge I_CLK) disable iff (!I_RST_B)
    !s1_valid_ff |=> $stable(O_PIX_DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel changed without sample");

  property p_narrow;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (s1_valid_ff && narrow) |=> (O_PIX_DATA[PIX_W-1:OUT8_W] == '0);
  endproperty
  a_narrow: assert property (p_narrow) else $error("8-bit output upper bits set");

  property p_exact;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (s1_valid_ff && s1_en_ff && !narrow && s1_frac == FRAC_ZERO)
      |=> (O_PIX_DATA == $past(s1_lo_ff));
  endproperty
  a_exact: assert property (p_exact) else $error("exact entry not used");

  property p_between;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (s1_valid_ff && s1_en_ff && !narrow && s1_lo_ff <= s1_hi_ff)
      |=> (O_PIX_DATA >= $past(s1_lo_ff) && O_PIX_DATA <= $past(s1_hi_ff));
  endproperty
  a_between: assert property (p_between) else $error("interpolation out of range");

  property p_top_addr;
    @(posedge I_CLK) (I_PIX_DATA > LAST_USED) |-> (lo_idx == LAST_USED && hi_idx == LAST_USED);
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("saturation address wrong");

  property p_used_addr;
    @(posedge I_CLK) lo_idx[STEP_SHIFT-1:0] == FRAC_ZERO && hi_idx[STEP_SHIFT-1:0] == FRAC_ZERO;
  endproperty
  a_used_addr: assert property (p_used_addr) else $error("unused entry addressed");

  property p_index;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_idx |=> (table_entry_index_ff == $past(I_AVS_WRITEDATA[IDX_W-1:0]));
  endproperty
  a_index: assert property (p_index) else $error("index not stored");

  property p_enable;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_ctrl |=> (table_enable_ff == $past(I_AVS_WRITEDATA[CTRL_EN_BIT]));
  endproperty
  a_enable: assert property (p_enable) else $error("enable not stored");

  property p_selector;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (st_ff == ST_READ && hit_sel) |=> (O_AVS_READDATA == SELECTOR_LUMINANCE);
  endproperty
  a_selector: assert property (p_selector) else $error("selector not luminance");

  // Register bus checks
  property p_read_wait;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_AVS_READ && st_ff == ST_IDLE) |-> s_read_fetch;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");

  property p_write_nowait;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_AVS_WRITE && st_ff == ST_IDLE) |-> !O_AVS_WAITREQUEST;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");

  property p_value_store;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_val |-> ##2 (rd_entry_ff == $past(wdata12, 2));
  endproperty
  a_value_store: assert property (p_value_store) else $error("table value not stored");

  property p_ctrl_refused;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_AVS_WRITE && hit_ctrl && !be_lo) |=> ($stable(table_enable_ff) && $stable(fmt_ff));
  endproperty
  a_ctrl_refused: assert property (p_ctrl_refused) else $error("ctrl write not refused");

  property p_format;
    @(posedge I_CLK) disable iff (!I_RST_B)
    wr_ctrl |=> (fmt_ff == $past(I_AVS_WRITEDATA[CTRL_FMT_LSB +: CTRL_FMT_W]));
  endproperty
  a_format: assert property (p_format) else $error("format not stored");

  property p_sel_ignored;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (I_AVS_WRITE && hit_sel)
      |=> ($stable(table_enable_ff) && $stable(table_entry_index_ff));
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("selector write leaked");

  property p_unmapped;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (st_ff == ST_READ && hit_none) |=> (O_AVS_READDATA == UNMAPPED_READ);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_index_read;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (st_ff == ST_READ && hit_idx)
      |=> (O_AVS_READDATA[IDX_W-1:0] == $past(table_entry_index_ff));
  endproperty
  a_index_read: assert property (p_index_read) else $error("index read-back wrong");

  property p_ctrl_read;
    @(posedge I_CLK) disable iff (!I_RST_B)
    (st_ff == ST_READ && hit_ctrl)
      |=> (O_AVS_READDATA[CTRL_EN_BIT] == $past(table_enable_ff));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("enable read-back wrong");

endmodule

`default_nettype wire

// ---- verification/plut_adc_model.sv ----
// Sensor converter model: presents one 12-bit sample per call of send.
// Assumes the caller ends each burst with idle; the block has no backpressure.
`timescale 1ns/100ps
`default_nettype none
module plut_adc_model
(
  input  wire logic        i_clk,
  output var  logic [11:0] o_pix_data,
  output var  logic        o_pix_valid
);
  initial
  begin
    o_pix_data  = 12'h000;
    o_pix_valid = 1'b0;
  end
  // Full-width sample, one per edge
  task automatic send(input logic [11:0] s);
    @(posedge i_clk);
    o_pix_data  <= s;
    o_pix_valid <= 1'b1;
  endtask
  // Released lines show the inverse of the last value
  task automatic idle();
    @(posedge i_clk);
    o_pix_valid <= 1'b0;
    o_pix_data  <= ~o_pix_data;
  endtask
endmodule
`default_nettype wire

// ---- verification/plut_top_tb.sv ----
// Testbench for the pixel lookup: Avalon-MM tasks and a pixel scoreboard.
// Assumes plut_pkg, plut_top and plut_adc_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module plut_top_tb
  import plut_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0]  be = 4'hF;
  logic [31:0] rdata;
  logic [31:0] junk;
  logic        wq;
  logic [11:0] pd;
  logic [11:0] od;
  logic        pv;
  logic        ov;
  logic [1:0]  vp = 2'h0;
  logic        en = 1'b0;
  logic [1:0]  fmt = 2'h0;
  logic [11:0] tm [0:4095];
  logic [11:0] q [$];
  logic [11:0] ti [12] = '{12'h000, 12'h008, 12'h010, 12'h018, 12'hFF0, 12'hFF8,
                           12'h004, 12'h00C, 12'h001, 12'h007, 12'hFF9, 12'hFFF};
  logic [11:0] tv [12] = '{12'h100, 12'h900, 12'h300, 12'hFFF, 12'h010, 12'hABC,
                           12'h777, 12'h555, 12'hFFF, 12'h000, 12'h123, 12'hFFF};
  logic [11:0] smp [12] = '{12'h000, 12'h008, 12'h00C, 12'h00D, 12'h010, 12'h014,
                            12'h017, 12'h005, 12'hFF4, 12'hFF8, 12'hFF9, 12'hFFF};
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  plut_top u_dut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq), .I_PIX_DATA(pd),
    .I_PIX_VALID(pv), .O_PIX_DATA(od), .O_PIX_VALID(ov));

  plut_adc_model u_adc (.i_clk(clk), .o_pix_data(pd), .o_pix_valid(pv));

  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t register got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp12(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t pixel got %h expected %h", $time, g, e);
    end
  endtask

  task final_report;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do
      @(posedge clk);
    while (wq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    cmp32(r, e);
  endtask

  task automatic set_ent(input logic [11:0] i, input logic [11:0] v);
    bus(1'b1, REG_INDEX, {20'h0_0000, i}, junk);
    bus(1'b1, REG_VALUE, {20'h0_0000, v}, junk);
    tm[i] = v;
  endtask

  task automatic set_ctrl(input logic e, input logic [1:0] f);
    bus(1'b1, REG_CTRL, {26'h000_0000, f, 3'h0, e}, junk);
    en  = e;
    fmt = f;
  endtask

  function automatic logic [11:0] expf(input logic [11:0] s);
    int lo;
    int hi;
    int d;
    logic [11:0] r;
    lo = tm[{s[11:3], 3'h0}];
    hi = tm[12'({s[11:3], 3'h0} + 12'h008)];
    d  = (hi - lo) * int'(s[2:0]);
    r  = 12'(lo + (d >>> 3));
    if (s >= 12'hFF8)
      r = tm[12'hFF8];
    if (!en)
      r = s;
    if (fmt >= 2'h2)
      r = {4'h0, r[11:4]};
    return r;
  endfunction

  task automatic burst(input int n);
    for (int k = 0; k < n; k++)
    begin
      q.push_back(expf(smp[k]));
      u_adc.send(smp[k]);
    end
    u_adc.idle();
    repeat (4) @(posedge clk);
  endtask

  always @(posedge clk)
    vp <= {vp[0], pv & rst_b};

  always @(negedge clk)
    if (rst_b)
    begin
      cmp12({11'h000, ov}, {11'h000, vp[1]});
      if (ov === 1'b1)
        cmp12(od, (q.size() > 0) ? q.pop_front() : 12'hxxx);
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      final_report;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(REG_CTRL, 32'h0000_0000);
    rd_chk(REG_INDEX, 32'h0000_0000);
    bus(1'b1, REG_SELECTOR, 32'h0000_0005, junk);
    rd_chk(REG_SELECTOR, SELECTOR_LUMINANCE);
    bus(1'b1, 4'h1, 32'hFFFF_FFFF, junk);
    rd_chk(4'h1, UNMAPPED_READ);
    burst(12);
    set_ctrl(1'b0, FMT_MOSAIC_8);
    burst(12);
    for (int k = 0; k < 12; k++)
      set_ent(ti[k], tv[k]);
    bus(1'b1, REG_INDEX, 32'h0000_0010, junk);
    rd_chk(REG_VALUE, 32'h0000_0300);
    be <= 4'h2;
    bus(1'b1, REG_VALUE, 32'h0000_0EEE, junk);
    bus(1'b1, REG_CTRL, 32'h0000_0001, junk);
    be <= 4'hF;
    rd_chk(REG_VALUE, 32'h0000_0300);
    rd_chk(REG_CTRL, 32'h0000_0020);
    for (int f = 0; f < 4; f++)
    begin
      set_ctrl(1'b1, 2'(f));
      burst(12);
    end
    set_ctrl(1'b0, FMT_MOSAIC_12P);
    burst(4);
    cmp32(32'(q.size()), 32'h0000_0000);
    final_report;
  end
endmodule
`default_nettype wire
